// ### timer_mode_select.sv
// Mode decoder for a two-half general timer with an AXI4-Lite register slave.
//
// Contract
// [RULE_01] Half A mode field: 1 one-shot, 2 periodic, 3 capture, 0 reserved.
// [RULE_02] In 16-bit arrangement half A field sets only the first 16-bit timer.
// [RULE_03] In 32-bit arrangement combined timer mode comes only from half A register.
// [RULE_04] Both mode fields are read according to the configuration low three bits.
// [RULE_05] Half B mode field bits 1:0 decode identically to half A.
// [RULE_06] In 16-bit arrangement half B bits choose the second 16-bit timer mode.
// [RULE_07] In 32-bit arrangement every half B field is ignored.
// [RULE_08] Software sets alt-select 1, capture-style 0, mode periodic for PWM.
// [RULE_09] Alt-select 0 capture, 1 PWM; capture-style 0 edge-count, 1 edge-time.
// [RULE_10] Config 0 32-bit timer, 1 RTC, 2-3 reserved, 4-7 two 16-bit timers.
`timescale 1ns/1ps
module timer_mode_select
    import timer_mode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [CFG_W-1:0] o_arrangement_config,
    output arrangement_t o_arrangement,
    output timer_op_t o_timer_a_op,
    output timer_op_t o_timer_b_op
);

    // How the decode path is organised.
    // Software writes three small registers: the arrangement field, the first half's mode
    // register and the second half's mode register. Each mode register holds a two-bit mode
    // field, a capture-style bit and an alternate-select bit in its low nibble.
    // The arrangement field is decoded first, because it decides how the mode registers are read.
    // In the 32-bit timer arrangement the first half's register alone sets the combined timer.
    // The second half's register is still stored and reads back, but it drives nothing there.
    // In the split arrangement each half's register sets its own 16-bit timer.
    // The counter arrangement and the reserved codes leave both decoded modes idle.
    // This keeps a half-programmed timer from starting in a mode that software never chose.
    // Every decoded mode is registered before it leaves the block.
    // The counting datapath therefore never sees a mix of old and new fields during a write.
    // The price is one cycle of delay between a register store and the new decoded mode.
    // Software can observe that delay over the bus, since the write response rises on the same edge as the store.
    //
    // Bus behaviour in short.
    // The write address and the write data are parked separately, so a master may offer them
    // in either order or together. The response follows once both are parked.
    // Each ready stays low from its handshake until the response has been taken.
    // A second write is therefore stalled rather than overlapped with the first.
    // Reads are answered one cycle after the address is taken and held until accepted.
    // Unmapped addresses answer with a slave error and change nothing.
    // The status word is read-only; writes to it are acknowledged and dropped.
    // Only byte lane 0 carries fields, so a write without lane 0 stores nothing.
    // Reserved bits above the fields are not stored and always read back as zero.
    // This avoids software depending on reserved bits that hold no state.

    // Address decode shared by the write and read channels, so both agree on the map.
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = (a == ADDR_ARRANGEMENT) || (a == ADDR_TIMER_A_MODE)
            || (a == ADDR_TIMER_B_MODE) || (a == ADDR_MODE_STATUS);
    endfunction : reg_mapped

    // The store path takes fields from write lane 0 only, so every field must fit one byte.
    if (MODE_REG_W > 8 || CFG_W > 8) begin : g_field_check
        $error("mode or arrangement field is wider than one byte lane");
    end

    // Arrangement decode from the three configuration bits.
    function automatic arrangement_t decode_arr(input logic [CFG_W-1:0] cfg);
        if (cfg[CFG_SPLIT_BIT]) begin
            decode_arr = ARR_16_SPLIT; // [RULE_10]
        end else if (cfg == CFG_32_TIMER) begin
            decode_arr = ARR_32_TIMER; // [RULE_10]
        end else if (cfg == CFG_32_RTC) begin
            decode_arr = ARR_32_RTC; // [RULE_10]
        end else begin
            decode_arr = ARR_RESERVED; // [RULE_10]
        end
    endfunction : decode_arr

    // Mode register decode, shared by both halves.
    function automatic timer_op_t decode_op(input logic [MODE_REG_W-1:0] r, input logic en);
        timer_op_t op;
        op = '0;
        if (en) begin
            case (mode_field_t'(r[MODE_MSB:MODE_LSB]))
                MODE_ONE_SHOT: op.one_shot = 1'b1; // [RULE_01] [RULE_05]
                MODE_PERIODIC: op.periodic = 1'b1; // [RULE_01] [RULE_05]
                MODE_CAPTURE: op.capture = 1'b1; // [RULE_01] [RULE_05]
                default: op.capture = 1'b0;
            endcase
            // Alternate select with capture style 0 turns periodic into PWM; otherwise capture stays capture.
            op.pwm = r[ALTSEL_BIT] && op.periodic && !r[CAPSTYLE_BIT]; // [RULE_09] [RULE_08]
            op.edge_time = !r[ALTSEL_BIT] && op.capture && r[CAPSTYLE_BIT]; // [RULE_09]
            op.active = op.one_shot | op.periodic | op.capture;
        end
        decode_op = op;
    endfunction : decode_op

    logic [CFG_W-1:0] cfg_q;
    logic [MODE_REG_W-1:0] a_mode_q;
    logic [MODE_REG_W-1:0] b_mode_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    arrangement_t arr_d;
    timer_op_t a_op_d;
    timer_op_t b_op_d;
    logic wr_fire;
    logic wr_hit;

    // Mode decode depends on arrangement; the RTC and reserved arrangements leave both idle.
    always_comb begin
        arr_d = decode_arr(cfg_q); // [RULE_04]
        case (arr_d)
            ARR_32_TIMER: begin
                a_op_d = decode_op(a_mode_q, 1'b1); // [RULE_03]
                b_op_d = '0; // [RULE_07]
            end
            ARR_16_SPLIT: begin
                a_op_d = decode_op(a_mode_q, 1'b1); // [RULE_02]
                b_op_d = decode_op(b_mode_q, 1'b1); // [RULE_06]
            end
            default: begin
                a_op_d = '0;
                b_op_d = '0;
            end
        endcase
    end

    // Registered decode outputs so the counting datapath sees glitch-free modes.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arrangement <= ARR_32_TIMER;
            o_timer_a_op <= '0;
            o_timer_b_op <= '0;
            o_arrangement_config <= CFG_RESET;
        end else begin
            o_arrangement <= arr_d;
            o_timer_a_op <= a_op_d;
            o_timer_b_op <= b_op_d;
            o_arrangement_config <= cfg_q;
        end
    end

    // Write address and data are each captured alone, so either may arrive first.
    assign wr_fire = aw_held_q && w_held_q && !o_bvalid;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (i_awvalid && o_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (i_wvalid && o_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Ready is held low while a beat is parked, which stalls a second write.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end else begin
            o_awready <= !aw_held_q && !(i_awvalid && o_awready) && !o_bvalid;
            o_wready <= !w_held_q && !(i_wvalid && o_wready) && !o_bvalid;
        end
    end

    // The parked write address is checked against the same map as the read channel.
    always_comb begin
        wr_hit = reg_mapped(awaddr_q);
    end

    // Register storage; only the low byte holds fields, so only lane 0 matters.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_q <= CFG_RESET;
            a_mode_q <= MODE_REG_RESET;
            b_mode_q <= MODE_REG_RESET;
        end else if (wr_fire && wstrb_q[0]) begin
            if (awaddr_q == ADDR_ARRANGEMENT) begin
                cfg_q <= wdata_q[CFG_W-1:0];
            end
            if (awaddr_q == ADDR_TIMER_A_MODE) begin
                a_mode_q <= wdata_q[MODE_REG_W-1:0];
            end
            // Stored even in 32-bit arrangement; it simply has no effect there.
            if (awaddr_q == ADDR_TIMER_B_MODE) begin
                b_mode_q <= wdata_q[MODE_REG_W-1:0]; // [RULE_07]
            end
        end
    end

    // Write response; the status register is read-only and writes to it are dropped.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read channel: one read at a time, answered the cycle after the address is taken.
    // Ready is registered, so a taken address always drops it for the following cycle.
    // The status word shows the registered decode, which is what the datapath really uses.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b0;
        end else begin
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp <= reg_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            o_rdata <= '0;
            case (i_araddr)
                ADDR_ARRANGEMENT: o_rdata[CFG_W-1:0] <= cfg_q;
                ADDR_TIMER_A_MODE: o_rdata[MODE_REG_W-1:0] <= a_mode_q;
                ADDR_TIMER_B_MODE: o_rdata[MODE_REG_W-1:0] <= b_mode_q;
                ADDR_MODE_STATUS: begin
                    o_rdata[ST_ARR_LSB +: 2] <= o_arrangement;
                    o_rdata[ST_A_LSB +: OP_W] <= o_timer_a_op;
                    o_rdata[ST_B_LSB +: OP_W] <= o_timer_b_op;
                end
                default: o_rresp <= RESP_SLVERR;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule : timer_mode_select

// ### timer_mode_pkg.sv
// Package with register map, field layouts and mode encodings for the timer mode selector.
package timer_mode_pkg;

    // Register byte offsets.
    localparam logic [11:0] ADDR_ARRANGEMENT = 12'h0000;
    localparam logic [11:0] ADDR_TIMER_A_MODE = 12'h0004;
    localparam logic [11:0] ADDR_TIMER_B_MODE = 12'h0008;
    localparam logic [11:0] ADDR_MODE_STATUS = 12'h0010;
    localparam int ADDR_W = 12;

    // Field positions inside the mode registers.
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam int CAPSTYLE_BIT = 2;
    localparam int ALTSEL_BIT = 3;
    localparam int MODE_REG_W = 4;
    localparam int CFG_W = 3;

    // Reset values.
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
    localparam logic [MODE_REG_W-1:0] MODE_REG_RESET = 4'h0;

    // Arrangement field values.
    localparam logic [CFG_W-1:0] CFG_32_TIMER = 3'h0;
    localparam logic [CFG_W-1:0] CFG_32_RTC = 3'h1;
    localparam int CFG_SPLIT_BIT = 2;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Two-bit mode field encodings.
    typedef enum logic [1:0] {
        MODE_RESERVED = 2'h0,
        MODE_ONE_SHOT = 2'h1,
        MODE_PERIODIC = 2'h2,
        MODE_CAPTURE = 2'h3
    } mode_field_t;

    // Arrangement decoded from the configuration field.
    typedef enum logic [1:0] {
        ARR_32_TIMER = 2'h0,
        ARR_32_RTC = 2'h1,
        ARR_RESERVED = 2'h2,
        ARR_16_SPLIT = 2'h3
    } arrangement_t;

    // Decoded operating mode of one timer.
    typedef struct packed {
        logic active;
        logic one_shot;
        logic periodic;
        logic capture;
        logic pwm;
        logic edge_time;
    } timer_op_t;

    // Status register field positions.
    localparam int ST_ARR_LSB = 0;
    localparam int ST_A_LSB = 4;
    localparam int ST_B_LSB = 12;
    localparam int OP_W = 6;

endpackage : timer_mode_pkg

// ### timer_mode_chk.sv
// Checker for the timer mode selector's decode outputs and bus answers.
`timescale 1ns/1ps
module timer_mode_chk
    import timer_mode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic o_rvalid,
    input wire logic [1:0] o_bresp,
    input wire logic [CFG_W-1:0] o_arrangement_config,
    input wire arrangement_t o_arrangement,
    input wire timer_op_t o_timer_a_op,
    input wire timer_op_t o_timer_b_op
);
    // Arrangement implied by the stored field; checked only once it has settled.
    arrangement_t arr_x;
    assign arr_x = o_arrangement_config[CFG_SPLIT_BIT] ? ARR_16_SPLIT :
        o_arrangement_config == CFG_32_TIMER ? ARR_32_TIMER :
        o_arrangement_config == CFG_32_RTC ? ARR_32_RTC : ARR_RESERVED;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_arr_decode: assert property ($stable(o_arrangement_config) |-> o_arrangement == arr_x)
        else $error("arrangement decode wrong");
    a_b_off_wide: assert property ((o_arrangement != ARR_16_SPLIT) [*2] |-> o_timer_b_op == '0)
        else $error("second half active outside split");
    a_a_off_rtc: assert property ((o_arrangement inside {ARR_32_RTC, ARR_RESERVED}) [*2]
        |-> o_timer_a_op == '0) else $error("first half active in counter mode");
    a_a_one_mode: assert property (o_timer_a_op.active |-> $onehot({o_timer_a_op.one_shot,
        o_timer_a_op.periodic, o_timer_a_op.capture})) else $error("first half mode not unique");
    a_b_one_mode: assert property (o_timer_b_op.active |-> $onehot({o_timer_b_op.one_shot,
        o_timer_b_op.periodic, o_timer_b_op.capture})) else $error("second half mode not unique");
    a_b_pwm_per: assert property (o_timer_b_op.pwm
        |-> o_timer_b_op.periodic && !o_timer_b_op.capture) else $error("pwm without periodic");
    a_b_edge_cap: assert property (o_timer_b_op.edge_time
        |-> o_timer_b_op.capture && !o_timer_b_op.pwm) else $error("edge time without capture");
    a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    a_wr_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write ready during response");
    // Main scenarios worth seeing at least once.
    cover property (o_timer_b_op.pwm);
    cover property (o_timer_a_op.edge_time);
    cover property (o_bvalid && o_bresp == RESP_SLVERR);
endmodule : timer_mode_chk

bind timer_mode_select timer_mode_chk chk_u (.*);

// ### tb.sv
// Self-checking testbench for the timer mode selector.
`timescale 1ns/1ps
module tb
    import timer_mode_pkg::*;
;
    logic i_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp;
    logic [2:0] o_arrangement_config;
    arrangement_t o_arrangement;
    timer_op_t o_timer_a_op, o_timer_b_op;
    int failures = 0;
    int checked = 0;

    timer_mode_select dut_u (.*);

    // Free-running 200 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic stop_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Address and data are offered together and each is released once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        @(posedge i_clk);
        i_awaddr <= a; i_wdata <= d; i_wstrb <= s;
        i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        i_bready <= 1'b0;
        chk(32'(o_bresp), 32'(er));
    endtask : wr

    // Data is only compared on an OKAY answer, since an error carries none.
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_clk);
        i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        i_rready <= 1'b0;
        chk(32'(o_rresp), 32'(er));
        if (er == RESP_OKAY) chk(o_rdata, ed);
    endtask : rd

    // Expected decode of one mode register; en is low where the half is unused.
    function automatic logic [5:0] eo(input logic [3:0] v, input logic en);
        logic [1:0] m;
        m = v[1:0];
        if (!en || m == 2'h0) return 6'h00;
        return {1'b1, m == 2'h1, m == 2'h2, m == 2'h3, v[3] && m == 2'h2 && !v[2],
            !v[3] && m == 2'h3 && v[2]};
    endfunction : eo

    task automatic t_reset;
        for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0000_0000, i == 3 ? RESP_SLVERR : RESP_OKAY);
        chk(32'(o_timer_a_op), 32'h0000_0000);
        chk(32'(o_arrangement), 32'h0000_0000);
    endtask : t_reset

    // Every arrangement against every value of both mode registers.
    task automatic t_combo;
        logic [5:0] xa, xb;
        arrangement_t xr;
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_ARRANGEMENT, 32'(c), 4'hF, RESP_OKAY);
            rd(ADDR_ARRANGEMENT, 32'(c), RESP_OKAY);
            xr = c > 3 ? ARR_16_SPLIT : c == 0 ? ARR_32_TIMER : c == 1 ? ARR_32_RTC : ARR_RESERVED;
            for (int m = 0; m < 16; m++) begin
                wr(ADDR_TIMER_A_MODE, 32'(m), 4'h1, RESP_OKAY);
                wr(ADDR_TIMER_B_MODE, 32'(15 - m), 4'h1, RESP_OKAY);
                repeat (2) @(posedge i_clk);
                xa = eo(4'(m), c == 0 || c > 3);
                xb = eo(4'(15 - m), c > 3);
                chk(32'(o_arrangement), 32'(xr));
                chk(32'(o_timer_a_op), 32'(xa));
                chk(32'(o_timer_b_op), 32'(xb));
                rd(ADDR_TIMER_B_MODE, 32'(15 - m), RESP_OKAY);
                rd(ADDR_MODE_STATUS, {14'h0, xb, 2'h0, xa, 2'h0, 2'(xr)}, RESP_OKAY);
            end
        end
    endtask : t_combo

    // Reserved bits, empty strobes, unmapped and read-only places.
    task automatic t_bus;
        wr(ADDR_TIMER_B_MODE, 32'h0000_000A, 4'h1, RESP_OKAY);
        wr(ADDR_TIMER_A_MODE, 32'hFFFF_FFFA, 4'hF, RESP_OKAY);
        rd(ADDR_TIMER_A_MODE, 32'h0000_000A, RESP_OKAY);
        chk(32'(o_timer_b_op), 32'h0000_002A);
        wr(ADDR_TIMER_A_MODE, 32'h0000_0001, 4'h0, RESP_OKAY);
        rd(ADDR_TIMER_A_MODE, 32'h0000_000A, RESP_OKAY);
        wr(12'h00C, 32'h0000_0000, 4'hF, RESP_SLVERR);
        wr(ADDR_MODE_STATUS, 32'h0000_0000, 4'hF, RESP_OKAY);
        rd(ADDR_ARRANGEMENT, 32'h0000_0007, RESP_OKAY);
        chk(32'(o_timer_a_op), 32'h0000_002A);
    endtask : t_bus

    // Watchdog against a hung handshake.
    initial begin
        #100us;
        failures++;
        stop_test();
    end

    // Main sequence.
    initial begin
        i_rstn = 1'b0; i_awvalid = 1'b0; i_wvalid = 1'b0; i_bready = 1'b0;
        i_arvalid = 1'b0; i_rready = 1'b0; i_awaddr = '0; i_araddr = '0;
        i_wdata = '0; i_wstrb = '0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_combo();
        t_bus();
        stop_test();
    end
endmodule : tb
